// File: logic/sensor_link_pkg.sv
// Constants, command codes, states and carrier types for the sensor link.
// Assumes one 100 MHz clock; all link timing is counted in microsecond ticks.
package sensor_link_pkg;

    // ------------------------------------------------------------
    // Clock and timebase
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 100_000_000;
    localparam int US_CYCLES       = CLK_HZ / 1_000_000;

    // ------------------------------------------------------------
    // Link timing, microseconds
    // ------------------------------------------------------------
    localparam int RESET_LOW_US    = 480;
    // Values inside the 15..60 and 60..240 windows
    localparam int PRES_WAIT_US    = 30;
    localparam int PRES_LOW_US     = 120;
    localparam int SAMPLE_US       = 30;
    // Read-zero held past 15 us, released well before 60 us
    localparam int READ_HOLD_US    = 30;

    // ------------------------------------------------------------
    // Function command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_CONVERT = 8'h44;
    localparam logic [7:0] CMD_WRITE   = 8'h4e;
    localparam logic [7:0] CMD_READ    = 8'hbe;
    localparam logic [7:0] CMD_DETECT  = 8'h88;
    localparam logic [7:0] CMD_SELECT  = 8'h70;

    // ------------------------------------------------------------
    // Buffer layout and reset values
    // ------------------------------------------------------------
    localparam int         BUF_BYTES    = 9;
    localparam int         TEMP_LSB_IDX = 0;
    localparam int         TEMP_MSB_IDX = 1;
    localparam int         STATUS_IDX   = 2;
    localparam int         WR_FIRST_IDX = 3;
    localparam int         WR_LAST_IDX  = 7;
    localparam int         CRC_IDX      = 8;
    localparam logic [7:0] BUF_RESET    = 8'h00;
    localparam logic [7:0] CRC_POLY_REV = 8'h8c;

    typedef enum logic [7:0] {
        ST_IDLE      = 8'h01,
        ST_PRES_WAIT = 8'h02,
        ST_PRES_LOW  = 8'h04,
        ST_CMD       = 8'h08,
        ST_SELECT    = 8'h10,
        ST_WRITE     = 8'h20,
        ST_READ      = 8'h40,
        ST_POLL      = 8'h80
    } link_state_t;

    typedef struct packed {
        logic [7:0] byte7;
        logic [7:0] byte6;
        logic [7:0] byte5;
        logic [7:0] byte4;
        logic [7:0] byte3;
    } host_cfg_t;

    typedef struct packed {
        logic       valid;
        logic [5:0] bits;
    } location_meas_t;

    typedef struct packed {
        logic        done;
        logic [15:0] value;
    } conv_result_t;

endpackage

// File: logic/single_wire_sensor_cmd_slots.sv
// Slave end of the single-wire sensor link: reset/presence, bit slots and
// function commands. Assumes the converter and strap measurement are outside,
// the data pin is open drain and resolved by the surroundings.
`timescale 1ns/100ps

module single_wire_sensor_cmd_slots #(
    parameter int US_CYCLES    = sensor_link_pkg::US_CYCLES,
    parameter int RESET_LOW_US = sensor_link_pkg::RESET_LOW_US
) (
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire logic                           dq_in,
    output logic                                dq_out,
    output logic                                dq_oe_n,
    input  wire logic                           ext_powered,
    input  wire logic                           auto_mode,
    input  wire logic                           conv_busy,
    input  wire sensor_link_pkg::conv_result_t  conv_result,
    output logic                                conv_start,
    output logic                                detect_req,
    input  wire sensor_link_pkg::location_meas_t location_meas,
    output sensor_link_pkg::host_cfg_t          host_cfg,
    output logic [5:0]                          location
);

    // ------------------------------------------------------------
    // Pin synchroniser and microsecond timebase
    // ------------------------------------------------------------
    logic        dq_s1;
    logic        dq_s2;
    logic        dq_prev;
    logic [15:0] div;
    logic        us_tick;
    logic [9:0]  low_us;
    logic [15:0] next_div;
    logic        next_us_tick;
    logic [9:0]  next_low_us;
    logic        fall;
    logic        rise;
    logic        long_low;

    assign fall     = dq_prev & ~dq_s2;
    assign rise     = ~dq_prev & dq_s2;
    // Gated by the line: the closing rise must not be swallowed as a reset
    assign long_low = ~dq_s2 && (low_us > 10'(RESET_LOW_US));

    always_comb begin
        next_us_tick = (div == 16'(US_CYCLES - 1));
        next_div     = next_us_tick ? 16'h0000 : div + 16'h0001;
        next_low_us  = low_us;
        if (dq_s2) begin
            next_low_us = 10'h000;
        end else if (us_tick && !long_low) begin
            next_low_us = low_us + 10'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dq_s1   <= 1'b1;
            dq_s2   <= 1'b1;
            dq_prev <= 1'b1;
            div     <= 16'h0000;
            us_tick <= 1'b0;
            low_us  <= 10'h000;
        end else begin
            dq_s1   <= dq_in;
            dq_s2   <= dq_s1;
            dq_prev <= dq_s2;
            div     <= next_div;
            us_tick <= next_us_tick;
            low_us  <= next_low_us;
        end
    end

    // ------------------------------------------------------------
    // Check code
    // ------------------------------------------------------------
    function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic bit_in);
        logic fb;
        fb = crc[0] ^ bit_in;
        crc_step = {1'b0, crc[7:1]} ^ (fb ? sensor_link_pkg::CRC_POLY_REV : 8'h00);
    endfunction

    // ------------------------------------------------------------
    // Protocol state machine, buffer and conversion tracking
    // ------------------------------------------------------------
    sensor_link_pkg::link_state_t state;
    sensor_link_pkg::link_state_t next_state;
    logic [7:0] mem [sensor_link_pkg::BUF_BYTES];
    logic [7:0] next_mem [sensor_link_pkg::BUF_BYTES];
    logic [7:0] tmr;
    logic [7:0] next_tmr;
    logic       in_slot;
    logic       next_in_slot;
    logic       armed;
    logic       next_armed;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [2:0] bit_idx;
    logic [2:0] next_bit_idx;
    logic [3:0] byte_idx;
    logic [3:0] next_byte_idx;
    logic [7:0] crc;
    logic [7:0] next_crc;
    logic       sel_pending;
    logic       next_sel_pending;
    logic       sel_match;
    logic       next_sel_match;
    logic       conv_running;
    logic       next_conv_running;
    logic       next_dq_oe_n;
    logic       next_conv_start;
    logic       next_detect_req;
    logic       tx_bit;
    logic [7:0] rx_byte;
    logic       sample;

    always_comb begin
        next_state        = state;
        next_mem          = mem;
        next_tmr          = tmr;
        next_in_slot      = in_slot;
        next_armed        = armed;
        next_shreg        = shreg;
        next_bit_idx      = bit_idx;
        next_byte_idx     = byte_idx;
        next_crc          = crc;
        next_sel_pending  = sel_pending;
        next_sel_match    = sel_match;
        next_conv_running = conv_running;
        next_dq_oe_n      = dq_oe_n;
        next_conv_start   = 1'b0;
        next_detect_req   = 1'b0;
        tx_bit            = (byte_idx == 4'(sensor_link_pkg::CRC_IDX)) ? crc[bit_idx]
                          : mem[byte_idx][bit_idx];
        sample            = in_slot && (tmr == 8'(sensor_link_pkg::SAMPLE_US));
        rx_byte           = {dq_s2, shreg[7:1]};

        if (us_tick && tmr != 8'hff) begin
            next_tmr = tmr + 8'h01;
        end

        // Converter side runs independently of the link
        if (conv_result.done) begin
            next_mem[sensor_link_pkg::TEMP_LSB_IDX] = conv_result.value[7:0];
            next_mem[sensor_link_pkg::TEMP_MSB_IDX] = conv_result.value[15:8];
            next_conv_running                       = 1'b0;
        end
        if (location_meas.valid) begin
            next_mem[sensor_link_pkg::STATUS_IDX] = {2'b00, location_meas.bits};
        end

        // Receive states share one bit sampler
        if (state inside {sensor_link_pkg::ST_CMD, sensor_link_pkg::ST_SELECT,
                          sensor_link_pkg::ST_WRITE}) begin
            if (fall) begin
                next_tmr     = 8'h00;
                next_in_slot = 1'b1;
            end else if (sample) begin
                next_in_slot = 1'b0;
                next_shreg   = rx_byte;
                next_bit_idx = bit_idx + 3'h1;
            end
        end

        unique case (state)
            sensor_link_pkg::ST_IDLE: begin
                // Silent until a reset pulse ends
                if (rise && armed) begin
                    next_state = sensor_link_pkg::ST_PRES_WAIT;
                    next_armed = 1'b0;
                    next_tmr   = 8'h00;
                end
            end
            sensor_link_pkg::ST_PRES_WAIT: begin
                if (tmr == 8'(sensor_link_pkg::PRES_WAIT_US)) begin
                    next_state   = sensor_link_pkg::ST_PRES_LOW;
                    next_dq_oe_n = 1'b0;
                    next_tmr     = 8'h00;
                end
            end
            sensor_link_pkg::ST_PRES_LOW: begin
                if (tmr == 8'(sensor_link_pkg::PRES_LOW_US)) begin
                    next_state       = sensor_link_pkg::ST_CMD;
                    next_dq_oe_n     = 1'b1;
                    next_bit_idx     = 3'h0;
                    next_in_slot     = 1'b0;
                    next_sel_pending = 1'b0;
                end
            end
            sensor_link_pkg::ST_CMD: begin
                if (sample && bit_idx == 3'h7) begin
                    next_state    = sensor_link_pkg::ST_IDLE;
                    next_byte_idx = 4'h0;
                    next_crc      = 8'h00;
                    if (rx_byte == sensor_link_pkg::CMD_SELECT && !sel_pending) begin
                        next_state = sensor_link_pkg::ST_SELECT;
                    end else if (sel_pending && !sel_match) begin
                        next_state = sensor_link_pkg::ST_IDLE;
                    end else if (rx_byte == sensor_link_pkg::CMD_CONVERT) begin
                        next_state = sensor_link_pkg::ST_POLL;
                        // Auto converter busy: command dropped, mode untouched
                        if (!(auto_mode && (conv_busy || conv_running))) begin
                            next_conv_start   = 1'b1;
                            next_conv_running = 1'b1;
                        end
                    end else if (rx_byte == sensor_link_pkg::CMD_WRITE) begin
                        next_state    = sensor_link_pkg::ST_WRITE;
                        next_byte_idx = 4'(sensor_link_pkg::WR_FIRST_IDX);
                    end else if (rx_byte == sensor_link_pkg::CMD_READ) begin
                        next_state = sensor_link_pkg::ST_READ;
                    end else if (rx_byte == sensor_link_pkg::CMD_DETECT) begin
                        next_detect_req = 1'b1;
                    end
                end
            end
            sensor_link_pkg::ST_SELECT: begin
                if (sample && bit_idx == 3'h7) begin
                    next_state       = sensor_link_pkg::ST_CMD;
                    next_sel_pending = 1'b1;
                    next_sel_match   = (rx_byte[7:6] == 2'b00) &&
                        (rx_byte[5:0] == mem[sensor_link_pkg::STATUS_IDX][5:0]);
                end
            end
            sensor_link_pkg::ST_WRITE: begin
                if (sample && bit_idx == 3'h7) begin
                    next_mem[byte_idx] = rx_byte;
                    next_byte_idx      = byte_idx + 4'h1;
                    if (byte_idx == 4'(sensor_link_pkg::WR_LAST_IDX)) begin
                        next_state = sensor_link_pkg::ST_IDLE;
                    end
                end
            end
            sensor_link_pkg::ST_READ: begin
                if (fall) begin
                    next_tmr     = 8'h00;
                    next_in_slot = 1'b1;
                    next_dq_oe_n = tx_bit;
                end else if (in_slot && tmr == 8'(sensor_link_pkg::READ_HOLD_US)) begin
                    next_in_slot = 1'b0;
                    next_dq_oe_n = 1'b1;
                    next_bit_idx = bit_idx + 3'h1;
                    if (byte_idx != 4'(sensor_link_pkg::CRC_IDX)) begin
                        next_crc = crc_step(crc, tx_bit);
                    end
                    if (bit_idx == 3'h7) begin
                        next_byte_idx = byte_idx + 4'h1;
                        if (byte_idx == 4'(sensor_link_pkg::CRC_IDX)) begin
                            next_state = sensor_link_pkg::ST_IDLE;
                        end
                    end
                end
            end
            sensor_link_pkg::ST_POLL: begin
                // Parasite supply: line held high by the pullup, stay released
                if (fall) begin
                    next_tmr     = 8'h00;
                    next_in_slot = 1'b1;
                    next_dq_oe_n = !(ext_powered && conv_running);
                end else if (in_slot && tmr == 8'(sensor_link_pkg::READ_HOLD_US)) begin
                    next_in_slot = 1'b0;
                    next_dq_oe_n = 1'b1;
                end
            end
        endcase

        // A long low overrides everything, including an open read
        if (long_low) begin
            next_state   = sensor_link_pkg::ST_IDLE;
            next_armed   = 1'b1;
            next_dq_oe_n = 1'b1;
            next_in_slot = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state        <= sensor_link_pkg::ST_IDLE;
            mem          <= '{default: sensor_link_pkg::BUF_RESET};
            tmr          <= 8'h00;
            in_slot      <= 1'b0;
            armed        <= 1'b0;
            shreg        <= 8'h00;
            bit_idx      <= 3'h0;
            byte_idx     <= 4'h0;
            crc          <= 8'h00;
            sel_pending  <= 1'b0;
            sel_match    <= 1'b0;
            conv_running <= 1'b0;
            dq_oe_n      <= 1'b1;
            dq_out       <= 1'b0;
            conv_start   <= 1'b0;
            detect_req   <= 1'b0;
            host_cfg     <= '0;
            location     <= 6'h00;
        end else begin
            state        <= next_state;
            mem          <= next_mem;
            tmr          <= next_tmr;
            in_slot      <= next_in_slot;
            armed        <= next_armed;
            shreg        <= next_shreg;
            bit_idx      <= next_bit_idx;
            byte_idx     <= next_byte_idx;
            crc          <= next_crc;
            sel_pending  <= next_sel_pending;
            sel_match    <= next_sel_match;
            conv_running <= next_conv_running;
            dq_oe_n      <= next_dq_oe_n;
            dq_out       <= 1'b0;
            conv_start   <= next_conv_start;
            detect_req   <= next_detect_req;
            host_cfg     <= {next_mem[7], next_mem[6], next_mem[5], next_mem[4], next_mem[3]};
            location     <= next_mem[sensor_link_pkg::STATUS_IDX][5:0];
        end
    end

endmodule

// File: tb/line_chk.sv
// Concurrent checks on the sensor link slave pins and side ports.
// Assumes binding to the top module, one clock, synchronous reset.
`timescale 1ns/100ps
module line_chk #(
    parameter int US_CYCLES = 100
) (
    input wire logic                            clk,
    input wire logic                            rst,
    input wire logic                            dq_in,
    input wire logic                            dq_out,
    input wire logic                            dq_oe_n,
    input wire logic                            auto_mode,
    input wire logic                            conv_busy,
    input wire logic                            conv_start,
    input wire logic                            detect_req,
    input wire sensor_link_pkg::location_meas_t location_meas,
    input wire logic [5:0]                      location
);
    // ------------------------------------------------------------
    // Run-length counters, saturating so long idle never wraps
    // ------------------------------------------------------------
    logic [15:0] lo_run, hi_run, drv_run;
    logic [15:0] next_lo_run, next_hi_run, next_drv_run;

    always_comb begin
        next_lo_run  = dq_in ? 16'h0 : lo_run + {15'h0, ~&lo_run};
        next_hi_run  = !dq_in ? 16'h0 : hi_run + {15'h0, ~&hi_run};
        next_drv_run = dq_oe_n ? 16'h0 : drv_run + {15'h0, ~&drv_run};
    end

    always_ff @(posedge clk) begin
        lo_run  <= rst ? 16'h0 : next_lo_run;
        hi_run  <= rst ? 16'h0 : next_hi_run;
        drv_run <= rst ? 16'h0 : next_drv_run;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("conv_start longer than one cycle");
    chk_detect_pulse: assert property (detect_req |=> !detect_req)
        else $error("detect_req longer than one cycle");
    chk_loc_load: assert property (
        location_meas.valid |=> location == $past(location_meas.bits))
        else $error("location not loaded from measurement");
    chk_auto_ignore: assert property (
        conv_start |-> !$past(auto_mode && conv_busy))
        else $error("conversion started while auto conversion busy");
    chk_drive_zero: assert property (!dq_oe_n |-> !dq_out)
        else $error("line driven with a high value");
    chk_drive_bound: assert property (drv_run < 125 * US_CYCLES)
        else $error("line held low by device too long");
    chk_release_shape: assert property (
        $rose(dq_oe_n) |-> drv_run <= 32 * US_CYCLES || drv_run >= 60 * US_CYCLES)
        else $error("device low pulse neither read bit nor presence");
    chk_drive_cause: assert property ($fell(dq_oe_n) |-> !$past(dq_in, 2) ||
        (hi_run >= 15 * US_CYCLES && hi_run <= 62 * US_CYCLES))
        else $error("device drove line outside a slot or presence window");
    chk_quiet_reset: assert property (lo_run >= 300 * US_CYCLES |-> dq_oe_n)
        else $error("device driving during a long low");
endmodule

bind single_wire_sensor_cmd_slots line_chk #(.US_CYCLES(US_CYCLES)) chk_i (
    .clk(clk), .rst(rst), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .auto_mode(auto_mode), .conv_busy(conv_busy), .conv_start(conv_start),
    .detect_req(detect_req), .location_meas(location_meas), .location(location));

// File: tb/line_master.sv
// Behavioural bus master for the single-wire line: reset, write and read slots.
// Assumes the line is the AND of all open-drain enables with a pull-up.
`timescale 1ns/100ps
module line_master #(
    parameter int US = 4
) (
    input  wire logic clk,
    input  wire logic line,
    output logic      oe_n
);
    initial oe_n = 1'b1;

    task automatic wait_us(input int n);
        repeat (n * US) @(posedge clk);
    endtask

    // Low well past the minimum, then listen late for presence
    task automatic init(output logic present);
        oe_n <= 1'b0;
        wait_us(490);
        oe_n <= 1'b1;
        wait_us(80);
        @(negedge clk) present = ~line;
        wait_us(120);
    endtask

    // A read is a write-one slot sampled near the end of the valid span
    task automatic slot(input logic wb, output logic rb);
        oe_n <= 1'b0;
        wait_us(2);
        if (wb) oe_n <= 1'b1;
        wait_us(10);
        @(negedge clk) rb = line;
        wait_us(50);
        oe_n <= 1'b1;
        wait_us(1);
    endtask

    task automatic put_byte(input logic [7:0] b);
        logic r;
        for (int i = 0; i < 8; i++) slot(b[i], r);
    endtask

    task automatic get_byte(output logic [7:0] b);
        for (int i = 0; i < 8; i++) slot(1'b1, b[i]);
    endtask
endmodule

// File: tb/tb.sv
// Self-checking bench: master model on the line, converter and strap models.
// Assumes a shortened microsecond tick so whole transactions stay short.
`timescale 1ns/100ps
module tb;
    localparam int US = 4;
    logic clk, rst, ext_powered, auto_mode, conv_busy, pres;
    logic dq_out, dq_oe_n, conv_start, detect_req, mst_oe_n;
    wire logic line;
    sensor_link_pkg::conv_result_t   conv_result;
    sensor_link_pkg::location_meas_t location_meas;
    sensor_link_pkg::host_cfg_t      host_cfg;
    logic [5:0] location;
    logic [7:0] rd, crc;
    logic [7:0] exp_buf [9];
    int         num_errors = 0, n_checks = 0, n_starts = 0, conv_left = 0;

    assign line = mst_oe_n & dq_oe_n;

    single_wire_sensor_cmd_slots #(.US_CYCLES(US)) dut (
        .clk(clk), .rst(rst), .dq_in(line), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .ext_powered(ext_powered), .auto_mode(auto_mode), .conv_busy(conv_busy),
        .conv_result(conv_result), .conv_start(conv_start), .detect_req(detect_req),
        .location_meas(location_meas), .host_cfg(host_cfg), .location(location));

    line_master #(.US(US)) mst (.clk(clk), .line(line), .oe_n(mst_oe_n));

    // ------------------------------------------------------------
    // Converter and strap models
    // ------------------------------------------------------------
    always @(posedge clk) begin
        conv_result.done <= 1'b0;
        location_meas.valid <= 1'b0;
        if (conv_start) n_starts++;
        if (conv_start) conv_left <= 400;
        else if (conv_left > 0) conv_left <= conv_left - 1;
        if (conv_left == 1) conv_result <= {1'b1, 16'h1234};
        if (detect_req) location_meas <= {1'b1, 6'h2a};
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input string name, input logic [39:0] exp, input logic [39:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic start(input logic [7:0] c);
        mst.init(pres);
        check("presence", 40'h1, {39'h0, pres});
        mst.put_byte(c);
    endtask

    task automatic results;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Whole sequence needs about 87k cycles
    initial begin
        repeat (98000) @(posedge clk);
        num_errors++;
        results;
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        ext_powered = 1'b1;
        auto_mode = 1'b0;
        conv_busy = 1'b0;
        conv_result = '0;
        location_meas = '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check("cfg_reset", 40'h0, host_cfg);
        check("loc_reset", 40'h0, {34'h0, location});
        start(8'h88);
        repeat (20) @(posedge clk);
        check("location", 40'h2a, {34'h0, location});
        start(8'h70);
        mst.put_byte(8'h2a);
        mst.put_byte(8'h4e);
        for (int i = 3; i < 8; i++) mst.put_byte(8'(8'h11 * i));
        check("cfg_select", 40'h7766554433, host_cfg);
        start(8'h70);
        mst.put_byte(8'h15);
        mst.put_byte(8'h4e);
        mst.put_byte(8'h00);
        check("cfg_mismatch", 40'h7766554433, host_cfg);
        start(8'h44);
        mst.slot(1'b1, rd[0]);
        check("busy_bit", 40'h0, {39'h0, rd[0]});
        rd[1] = 1'b0;
        for (int k = 0; k < 8 && rd[1] !== 1'b1; k++) mst.slot(1'b1, rd[1]);
        check("done_bit", 40'h1, {39'h0, rd[1]});
        check("starts", 40'h1, 40'(n_starts));
        auto_mode <= 1'b1;
        conv_busy <= 1'b1;
        start(8'h44);
        mst.wait_us(5);
        check("auto_ignored", 40'h1, 40'(n_starts));
        auto_mode <= 1'b0;
        conv_busy <= 1'b0;
        // Parasite supply: pullup holds the line, poll slots read released
        ext_powered <= 1'b0;
        start(8'h44);
        mst.slot(1'b1, rd[0]);
        check("parasite_bit", 40'h1, {39'h0, rd[0]});
        check("starts_parasite", 40'h2, 40'(n_starts));
        exp_buf = '{8'h34, 8'h12, 8'h2a, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h00};
        crc = 8'h00;
        for (int i = 0; i < 8; i++)
            for (int j = 0; j < 8; j++)
                crc = (crc >> 1) ^ ((crc[0] ^ exp_buf[i][j]) ? 8'h8c : 8'h00);
        exp_buf[8] = crc;
        start(8'hbe);
        for (int i = 0; i < 9; i++) begin
            mst.get_byte(rd);
            check("buffer", {32'h0, exp_buf[i]}, {32'h0, rd});
        end
        start(8'hbe);
        mst.get_byte(rd);
        start(8'h99);
        mst.get_byte(rd);
        check("silent", 40'hff, {32'h0, rd});
        results;
    end
endmodule
